// [include/clock_ctrl_pkg.sv]
package clock_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFS_PUMP_OVS_SEL  = 8'h11;
  localparam logic [7:0] OFS_PLL_REF_SEL   = 8'h12;
  localparam logic [7:0] OFS_RESYNC_CTRL   = 8'h13;
  localparam logic [7:0] OFS_PLL_PRE_DIV   = 8'h14;
  localparam logic [7:0] OFS_PLL_INT_MULT  = 8'h15;

  localparam logic [7:0] RST_PUMP_OVS_SEL  = 8'h00;
  localparam logic [7:0] RST_PLL_REF_SEL   = 8'h00;
  localparam logic [7:0] RST_RESYNC_CTRL   = 8'h10;
  localparam logic [7:0] RST_PLL_PRE_DIV   = 8'h01;
  localparam logic [7:0] RST_PLL_INT_MULT  = 8'h08;

  localparam int unsigned PUMP_SEL_LSB     = 4;
  localparam int unsigned OVS_SEL_LSB      = 0;
  localparam int unsigned REF_SEL_LSB      = 0;
  localparam int unsigned SEL_W            = 3;
  localparam int unsigned AUTO_REALIGN_BIT = 4;
  localparam int unsigned REALIGN_REQ_BIT  = 0;
  localparam int unsigned PRE_DIV_LSB      = 3;
  localparam int unsigned PRE_DIV_W        = 4;
  localparam int unsigned MULT_LSB         = 4;
  localparam int unsigned MULT_W           = 2;
  localparam int unsigned J_W              = 6;

  localparam logic [2:0] PIN_SEL_ZERO      = 3'h3;
  localparam logic [2:0] PIN_SEL_TWO       = 3'h5;
  localparam logic [3:0] PRE_DIV_BAD       = 4'hF;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic pump;
    logic oversample;
    logic pll_ref;
  } gpio_clk_s;

  typedef enum logic [1:0] {
    RS_RUN,
    RS_HELD,
    RS_ALIGN
  } resync_state_e;

endpackage : clock_ctrl_pkg

// [design/clock_gpio_source_resync_pll_div.sv]
module clock_gpio_source_resync_pll_div (
  input  wire logic                          clk_sys_i,
  input  wire logic                          nrst_i,
  input  wire clock_ctrl_pkg::reg_req_s      reg_req_i,
  output logic [clock_ctrl_pkg::DATA_W-1:0]  reg_rdata_o,
  input  wire logic                          general_pin_zero_i,
  input  wire logic                          general_pin_two_i,
  input  wire clock_ctrl_pkg::gpio_clk_s     src_is_gpio_i,
  output clock_ctrl_pkg::gpio_clk_s          gpio_clk_o,
  input  wire logic                          frame_start_i,
  input  wire logic                          dac_standby_exit_i,
  output logic                               clocks_halt_o,
  output logic                               dac_leave_standby_o,
  input  wire logic                          auto_clock_mode_i,
  input  wire logic [3:0]                    auto_pre_divide_i,
  output logic [4:0]                         pll_pre_divide_o,
  output logic [clock_ctrl_pkg::J_W-1:0]     pll_mult_j_o,
  output logic                               pll_cfg_error_o
);

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic pin_pick(input logic [2:0] sel, input logic en, input logic p0, input logic p2);
    logic r;
    r = 1'b0;
    if (en && sel == clock_ctrl_pkg::PIN_SEL_ZERO) begin
      r = p0;
    end else if (en && sel == clock_ctrl_pkg::PIN_SEL_TWO) begin
      r = p2;
    end
    return r;
  endfunction : pin_pick

  //////////////////////////////////////////////////////////////////////////////

  logic [7:0] pump_oversample_gpio_select_ff;
  logic [7:0] pll_reference_gpio_select_ff;
  logic [7:0] clock_resync_control_ff;
  logic [7:0] pll_pre_divider_ff;
  logic [7:0] pll_integer_multiplier_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_pump_oversample_gpio_select;
  logic [7:0] nxt_pll_reference_gpio_select;
  logic [7:0] nxt_clock_resync_control;
  logic [7:0] nxt_pll_pre_divider;
  logic [7:0] nxt_pll_integer_multiplier;
  logic [7:0] nxt_rdata;

  // Reserved bits are stored as written so software sees back what it wrote.
  always_comb begin
    nxt_pump_oversample_gpio_select = pump_oversample_gpio_select_ff;
    nxt_pll_reference_gpio_select   = pll_reference_gpio_select_ff;
    nxt_clock_resync_control        = clock_resync_control_ff;
    nxt_pll_pre_divider             = pll_pre_divider_ff;
    nxt_pll_integer_multiplier      = pll_integer_multiplier_ff;
    nxt_rdata                       = rdata_ff;
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        clock_ctrl_pkg::OFS_PUMP_OVS_SEL: nxt_pump_oversample_gpio_select = reg_req_i.wdata;
        clock_ctrl_pkg::OFS_PLL_REF_SEL:  nxt_pll_reference_gpio_select   = reg_req_i.wdata;
        clock_ctrl_pkg::OFS_RESYNC_CTRL:  nxt_clock_resync_control        = reg_req_i.wdata;
        clock_ctrl_pkg::OFS_PLL_PRE_DIV:  nxt_pll_pre_divider             = reg_req_i.wdata;
        clock_ctrl_pkg::OFS_PLL_INT_MULT: nxt_pll_integer_multiplier      = reg_req_i.wdata;
        default: ;
      endcase
    end
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        clock_ctrl_pkg::OFS_PUMP_OVS_SEL: nxt_rdata = pump_oversample_gpio_select_ff;
        clock_ctrl_pkg::OFS_PLL_REF_SEL:  nxt_rdata = pll_reference_gpio_select_ff;
        clock_ctrl_pkg::OFS_RESYNC_CTRL:  nxt_rdata = clock_resync_control_ff;
        clock_ctrl_pkg::OFS_PLL_PRE_DIV:  nxt_rdata = pll_pre_divider_ff;
        clock_ctrl_pkg::OFS_PLL_INT_MULT: nxt_rdata = pll_integer_multiplier_ff;
        default:                          nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pump_oversample_gpio_select_ff <= clock_ctrl_pkg::RST_PUMP_OVS_SEL;
      pll_reference_gpio_select_ff   <= clock_ctrl_pkg::RST_PLL_REF_SEL;
      clock_resync_control_ff        <= clock_ctrl_pkg::RST_RESYNC_CTRL;
      pll_pre_divider_ff             <= clock_ctrl_pkg::RST_PLL_PRE_DIV;
      pll_integer_multiplier_ff      <= clock_ctrl_pkg::RST_PLL_INT_MULT;
      rdata_ff                       <= 8'h00;
    end else begin
      pump_oversample_gpio_select_ff <= nxt_pump_oversample_gpio_select;
      pll_reference_gpio_select_ff   <= nxt_pll_reference_gpio_select;
      clock_resync_control_ff        <= nxt_clock_resync_control;
      pll_pre_divider_ff             <= nxt_pll_pre_divider;
      pll_integer_multiplier_ff      <= nxt_pll_integer_multiplier;
      rdata_ff                       <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////

  // Pins are asynchronous; a level is accepted only once stages two and three agree.
  logic [2:0] pin0_sync_ff;
  logic [2:0] pin2_sync_ff;
  logic       pin0_ff;
  logic       pin2_ff;
  logic [2:0] nxt_pin0_sync;
  logic [2:0] nxt_pin2_sync;
  logic       nxt_pin0;
  logic       nxt_pin2;

  always_comb begin
    nxt_pin0_sync = {pin0_sync_ff[1:0], general_pin_zero_i};
    nxt_pin2_sync = {pin2_sync_ff[1:0], general_pin_two_i};
    nxt_pin0      = (pin0_sync_ff[1] == pin0_sync_ff[2]) ? pin0_sync_ff[2] : pin0_ff;
    nxt_pin2      = (pin2_sync_ff[1] == pin2_sync_ff[2]) ? pin2_sync_ff[2] : pin2_ff;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin0_sync_ff <= 3'h0;
      pin2_sync_ff <= 3'h0;
      pin0_ff      <= 1'b0;
      pin2_ff      <= 1'b0;
    end else begin
      pin0_sync_ff <= nxt_pin0_sync;
      pin2_sync_ff <= nxt_pin2_sync;
      pin0_ff      <= nxt_pin0;
      pin2_ff      <= nxt_pin2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  clock_ctrl_pkg::gpio_clk_s gpio_clk_ff;
  clock_ctrl_pkg::gpio_clk_s nxt_gpio_clk;

  // Muted means held low, so a bad code never lets a glitching pin through.
  always_comb begin
    nxt_gpio_clk.pump       = pin_pick(pump_oversample_gpio_select_ff[clock_ctrl_pkg::PUMP_SEL_LSB +: 3],
                                       src_is_gpio_i.pump, pin0_ff, pin2_ff);
    nxt_gpio_clk.oversample = pin_pick(pump_oversample_gpio_select_ff[clock_ctrl_pkg::OVS_SEL_LSB +: 3],
                                       src_is_gpio_i.oversample, pin0_ff, pin2_ff);
    nxt_gpio_clk.pll_ref    = pin_pick(pll_reference_gpio_select_ff[clock_ctrl_pkg::REF_SEL_LSB +: 3],
                                       src_is_gpio_i.pll_ref, pin0_ff, pin2_ff);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gpio_clk_ff <= '0;
    end else begin
      gpio_clk_ff <= nxt_gpio_clk;
    end
  end

  assign gpio_clk_o = gpio_clk_ff;

  //////////////////////////////////////////////////////////////////////////////

  clock_ctrl_pkg::resync_state_e state_ff;
  clock_ctrl_pkg::resync_state_e nxt_state;
  logic                          auto_pending_ff;
  logic                          nxt_auto_pending;
  logic                          halt_ff;
  logic                          nxt_halt;
  logic                          leave_ff;
  logic                          nxt_leave;
  logic                          req_bit;
  logic                          auto_en;

  assign req_bit = clock_resync_control_ff[clock_ctrl_pkg::REALIGN_REQ_BIT];
  assign auto_en = clock_resync_control_ff[clock_ctrl_pkg::AUTO_REALIGN_BIT];

  // A standby exit that arrives during a manual realign is held and released with it.
  always_comb begin
    nxt_state        = state_ff;
    nxt_auto_pending = auto_pending_ff | dac_standby_exit_i;
    nxt_leave        = 1'b0;
    unique case (state_ff)
      clock_ctrl_pkg::RS_RUN: begin
        if (req_bit) begin
          nxt_state = clock_ctrl_pkg::RS_HELD;
        end else if (dac_standby_exit_i && auto_en) begin
          nxt_state = clock_ctrl_pkg::RS_ALIGN;
        end else if (dac_standby_exit_i) begin
          nxt_auto_pending = 1'b0;
          nxt_leave        = 1'b1;
        end
      end
      clock_ctrl_pkg::RS_HELD: begin
        if (!req_bit) begin
          nxt_state = clock_ctrl_pkg::RS_ALIGN;
        end
      end
      clock_ctrl_pkg::RS_ALIGN: begin
        if (req_bit) begin
          nxt_state = clock_ctrl_pkg::RS_HELD;
        end else if (frame_start_i) begin
          nxt_state        = clock_ctrl_pkg::RS_RUN;
          nxt_leave        = nxt_auto_pending;
          nxt_auto_pending = 1'b0;
        end
      end
    endcase
    nxt_halt = (nxt_state != clock_ctrl_pkg::RS_RUN);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff        <= clock_ctrl_pkg::RS_RUN;
      auto_pending_ff <= 1'b0;
      halt_ff         <= 1'b0;
      leave_ff        <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      auto_pending_ff <= nxt_auto_pending;
      halt_ff         <= nxt_halt;
      leave_ff        <= nxt_leave;
    end
  end

  assign clocks_halt_o       = halt_ff;
  assign dac_leave_standby_o = leave_ff;

  //////////////////////////////////////////////////////////////////////////////

  logic [4:0]                    pre_div_ff;
  logic [4:0]                    nxt_pre_div;
  logic [clock_ctrl_pkg::J_W-1:0] mult_j_ff;
  logic [clock_ctrl_pkg::J_W-1:0] nxt_mult_j;
  logic                          cfg_err_ff;
  logic                          nxt_cfg_err;
  logic [3:0]                    pre_code;

  // Code 1111 is prohibited; it is still passed on and flagged in manual mode only (not in auto mode), not silently fixed.
  always_comb begin
    pre_code    = auto_clock_mode_i ? auto_pre_divide_i
                                    : pll_pre_divider_ff[clock_ctrl_pkg::PRE_DIV_LSB +: 4];
    nxt_pre_div = {1'b0, pre_code} + 5'h01;
    nxt_mult_j  = {4'h0, pll_integer_multiplier_ff[clock_ctrl_pkg::MULT_LSB +: 2]};
    nxt_cfg_err = !auto_clock_mode_i &&
                  ((pre_code == clock_ctrl_pkg::PRE_DIV_BAD) || (nxt_mult_j == 6'h00));
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_div_ff <= 5'h01;
      mult_j_ff  <= 6'h00;
      cfg_err_ff <= 1'b0;
    end else begin
      pre_div_ff <= nxt_pre_div;
      mult_j_ff  <= nxt_mult_j;
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  assign pll_pre_divide_o = pre_div_ff;
  assign pll_mult_j_o     = mult_j_ff;
  assign pll_cfg_error_o  = cfg_err_ff;

endmodule : clock_gpio_source_resync_pll_div

// [tb/clock_ctrl_sva.sv]
module clock_ctrl_sva (
  input wire logic                         clk_sys_i,
  input wire logic                         nrst_i,
  input wire clock_ctrl_pkg::reg_req_s     reg_req_i,
  input wire clock_ctrl_pkg::gpio_clk_s    src_is_gpio_i,
  input wire clock_ctrl_pkg::gpio_clk_s    gpio_clk_o,
  input wire logic                         frame_start_i,
  input wire logic                         clocks_halt_o,
  input wire logic                         dac_leave_standby_o,
  input wire logic                         auto_clock_mode_i,
  input wire logic [3:0]                   auto_pre_divide_i,
  input wire logic [4:0]                   pll_pre_divide_o,
  input wire logic [clock_ctrl_pkg::J_W-1:0] pll_mult_j_o,
  input wire logic                         pll_cfg_error_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////
  auto_div_a: assert property ($past(auto_clock_mode_i) && $past(nrst_i)
    |-> pll_pre_divide_o == {1'b0, $past(auto_pre_divide_i)} + 5'h01) else $error("auto divide wrong");
  auto_noerr_a: assert property ($past(auto_clock_mode_i) && $past(nrst_i)
    |-> !pll_cfg_error_o) else $error("error flag in auto mode");
  bad_div_a: assert property (pll_pre_divide_o == 5'h10 && !$past(auto_clock_mode_i)
    |-> pll_cfg_error_o) else $error("prohibited divider not flagged");
  mult_width_a: assert property (pll_mult_j_o[5:2] == 4'h0) else $error("multiplier too wide");
  // The width check alone would hold even with the field taken from the wrong bits.
  mult_track_a: assert property (reg_req_i.wr && reg_req_i.addr == 8'h15
    |-> ##2 pll_mult_j_o == {4'h0, $past(reg_req_i.wdata[5:4], 2)}) else $error("multiplier field wrong");
  halt_req_a: assert property (reg_req_i.wr && reg_req_i.addr == 8'h13 && reg_req_i.wdata[0]
    |-> ##[1:3] clocks_halt_o) else $error("halt missing after request");
  halt_frame_a: assert property ($fell(clocks_halt_o)
    |-> $past(frame_start_i) || $past(frame_start_i, 2)) else $error("halt released off frame");
  leave_once_a: assert property (dac_leave_standby_o |=> !dac_leave_standby_o) else $error("leave too long");
  pump_mute_a: assert property (!$past(src_is_gpio_i.pump) && !src_is_gpio_i.pump
    |-> !gpio_clk_o.pump) else $error("pump clock not muted");
endmodule : clock_ctrl_sva
////////////////////////////////////////////////////////////
bind clock_gpio_source_resync_pll_div clock_ctrl_sva u_sva (.clk_sys_i, .nrst_i, .reg_req_i,
  .src_is_gpio_i, .gpio_clk_o, .frame_start_i, .clocks_halt_o, .dac_leave_standby_o,
  .auto_clock_mode_i, .auto_pre_divide_i, .pll_pre_divide_o, .pll_mult_j_o, .pll_cfg_error_o);

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                      clk_sys_i = 1'b0;
  logic                      nrst_i = 1'b0;
  clock_ctrl_pkg::reg_req_s  reg_req_i = '0;
  logic [7:0]                rdata;
  logic                      pin0 = 1'b0;
  logic                      pin2 = 1'b0;
  clock_ctrl_pkg::gpio_clk_s src = '0;
  clock_ctrl_pkg::gpio_clk_s gclk;
  logic                      frame_start_i = 1'b0;
  logic                      exit_p = 1'b0;
  logic                      clocks_halt_o;
  logic                      leave;
  logic                      auto_m = 1'b0;
  logic [3:0]                auto_p = 4'h0;
  logic [4:0]                pre;
  logic [5:0]                mult;
  logic                      err;
  int                        failures = 0;
  int                        compares = 0;
  int                        cycles = 0;
  clock_gpio_source_resync_pll_div uut (.clk_sys_i, .nrst_i, .reg_req_i, .reg_rdata_o(rdata),
    .general_pin_zero_i(pin0), .general_pin_two_i(pin2), .src_is_gpio_i(src), .gpio_clk_o(gclk),
    .frame_start_i, .dac_standby_exit_i(exit_p), .clocks_halt_o, .dac_leave_standby_o(leave),
    .auto_clock_mode_i(auto_m), .auto_pre_divide_i(auto_p), .pll_pre_divide_o(pre),
    .pll_mult_j_o(mult), .pll_cfg_error_o(err));
  ////////////////////////////////////////////////////////////
  always #2.5 clk_sys_i = ~clk_sys_i;
  // A hang in any wait loop ends here rather than running forever.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic waitn(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : waitn
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_req_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys_i);
    reg_req_i = '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys_i);
    reg_req_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys_i);
    reg_req_i = '0;
    @(negedge clk_sys_i);
    chk(rdata, e, "read data");
  endtask : rd
  // Pulses frame and/or standby exit, then counts leave pulses seen.
  task automatic pulse(input logic f, input logic x, output int n);
    @(negedge clk_sys_i);
    frame_start_i = f;
    exit_p = x;
    @(negedge clk_sys_i);
    frame_start_i = 1'b0;
    exit_p = 1'b0;
    n = int'(leave);
    repeat (5) begin
      @(negedge clk_sys_i);
      n += int'(leave);
    end
  endtask : pulse
  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    logic e;
    int   n;
    repeat (20) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    rd(8'h11, 8'h00);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h10);
    rd(8'h14, 8'h01);
    rd(8'h15, 8'h08);
    rd(8'h16, 8'h00);
    chk({3'b0, pre}, 8'h01, "divide");
    for (int j = 1; j < 4; j++) begin
      wr(8'h15, 8'(j * 16 + 8));
      waitn(2);
      chk({2'b0, mult}, 8'(j), "j factor");
    end
    rd(8'h15, 8'h38);
    wr(8'h14, 8'h71);
    waitn(2);
    chk({2'b0, err, pre}, 8'h0F, "divide");
    wr(8'h14, 8'h79);
    waitn(2);
    chk({2'b0, err, pre}, 8'h30, "divide");
    auto_m = 1'b1;
    auto_p = 4'hF;
    waitn(2);
    chk({2'b0, err, pre}, 8'h10, "auto divide");
    auto_m = 1'b0;
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h01);
    src = '1;
    for (int c = 0; c < 8; c++) begin
      wr(8'h11, 8'(c * 17));
      wr(8'h12, 8'(c));
      for (int p = 0; p < 2; p++) begin
        pin0 = p[0];
        pin2 = !p[0];
        waitn(8);
        e = (c == 3) ? p[0] : (c == 5) ? !p[0] : 1'b0;
        chk({5'b0, gclk}, {5'b0, {3{e}}}, "gpio clock");
      end
    end
    src = '0;
    pin0 = 1'b1;
    wr(8'h11, 8'h33);
    wr(8'h12, 8'h03);
    waitn(8);
    chk({5'b0, gclk}, 8'h00, "gated clock");
    wr(8'h13, 8'h11);
    waitn(3);
    chk({7'b0, clocks_halt_o}, 8'h01, "halt");
    pulse(1'b1, 1'b0, n);
    chk({7'b0, clocks_halt_o}, 8'h01, "halt");
    wr(8'h13, 8'h10);
    waitn(3);
    chk({7'b0, clocks_halt_o}, 8'h01, "halt");
    pulse(1'b1, 1'b0, n);
    chk({7'b0, clocks_halt_o}, 8'h00, "halt");
    chk(8'(n), 8'h00, "leave count");
    pulse(1'b0, 1'b1, n);
    chk({7'b0, clocks_halt_o}, 8'h01, "halt");
    pulse(1'b1, 1'b0, n);
    chk({7'b0, clocks_halt_o}, 8'h00, "halt");
    chk(8'(n), 8'h01, "leave count");
    wr(8'h13, 8'h00);
    pulse(1'b0, 1'b1, n);
    chk({7'b0, clocks_halt_o}, 8'h00, "halt");
    chk(8'(n), 8'h01, "leave count");
    // A reset in mid-run must bring the realign enable back on.
    nrst_i = 1'b0;
    waitn(2);
    nrst_i = 1'b1;
    rd(8'h13, 8'h10);
    chk({7'b0, clocks_halt_o}, 8'h00, "halt");
    print_verdict;
  end
endmodule : testbench
